// ===== core/gpc_consts.svh
// Register offsets, field positions and reset values of the pin control block
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH
`define GPC_ADDR_W 12
`define GPC_OFF_BANK0 12'h280
`define GPC_OFF_BANK1 12'h284
`define GPC_OFF_BANK2 12'h288
`define GPC_OFF_CTL_BASE 12'h000
`define GPC_OFF_CTL2_BASE 12'h100
`define GPC_NPINS 8
`define GPC_PIN_IDX_W 3
`define GPC_PIN_IDX_LSB 2
`define GPC_BANK0_MASK 32'h7fffffff
`define GPC_BANK1_MASK 32'h00ffffff
`define GPC_BANK2_MASK 32'h7fffffff
`define GPC_CTL_MASK 32'h000107ff
`define GPC_CTL2_MASK 32'h00000031
`define GPC_CTL_RST 32'h00000000
`define GPC_CTL2_RST 32'h00000000
`define GPC_CTL_PULL_LSB 0
`define GPC_CTL_PWR_LSB 2
`define GPC_CTL_DET_LSB 4
`define GPC_CTL_EDGE_BIT 7
`define GPC_CTL_OD_BIT 8
`define GPC_CTL_DIR_BIT 9
`define GPC_CTL_SRC_BIT 10
`define GPC_CTL_ALT_BIT 16
`define GPC_CTL2_SLEW_BIT 0
`define GPC_CTL2_DRV_LSB 4
`define GPC_NOPD_MASK 8'h00
`endif

// ===== core/gpc_pkg.sv
// Types shared by the pin control block
package gpc_pkg;
  typedef enum logic [1:0] {
    GPC_PULL_NONE = 2'b00,
    GPC_PULL_UP = 2'b01,
    GPC_PULL_DOWN = 2'b10,
    GPC_PULL_NONE2 = 2'b11
  } gpc_pull_t;
  typedef enum logic [1:0] {
    GPC_PWR_MAIN = 2'b00,
    GPC_PWR_SEC = 2'b01,
    GPC_PWR_RSV2 = 2'b10,
    GPC_PWR_RSV3 = 2'b11
  } gpc_pwr_t;
  typedef enum logic [3:0] {
    GPC_DET_LOW = 4'b0000,
    GPC_DET_HIGH = 4'b0001,
    GPC_DET_OFF = 4'b0100,
    GPC_DET_RISE = 4'b1101,
    GPC_DET_FALL = 4'b1110,
    GPC_DET_BOTH = 4'b1111
  } gpc_det_t;
endpackage

// ===== core/gpc_pin_event.sv
// Per-pin input synchroniser and level or edge event detector
`timescale 1ns/100ps
`include "gpc_consts.svh"
module gpc_pin_event (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pin_in,
  input wire logic [3:0] det_mode,
  output logic event_r,
  output logic edge_event_r
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic rise;
  logic fall;
  logic lvl_hit;
  logic edge_hit;
  logic event_nxt;

  // Edges are judged on the second synchroniser stage only
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;
  assign lvl_hit = (det_mode == gpc_pkg::GPC_DET_LOW) ? ~sync2_r :
                   (det_mode == gpc_pkg::GPC_DET_HIGH) ? sync2_r : 1'b0;
  assign edge_hit = (det_mode == gpc_pkg::GPC_DET_RISE) ? rise :
                    (det_mode == gpc_pkg::GPC_DET_FALL) ? fall :
                    (det_mode == gpc_pkg::GPC_DET_BOTH) ? (rise | fall) : 1'b0;
  assign event_nxt = lvl_hit | edge_hit;

  // Two-flop synchroniser runs through reset: a cleared stage would fake a low
  // level and a rising edge on an idle high pin just after release
  always_ff @(posedge mclk)
  begin
    sync1_r <= pin_in;
    sync2_r <= sync1_r;
    prev_r <= sync2_r;
  end

  // Event registers
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      event_r <= 1'b0;
      edge_event_r <= 1'b0;
    end
    else
    begin
      event_r <= event_nxt;
      edge_event_r <= edge_hit;
    end
  end
endmodule

// ===== core/gpc_top.sv
// Pin control, output data and event logic for a group of GPIO pins
// Summary of operation
// - Rail field 00: tristate when main rail bad
// - Rail field 01: tristate on secondary rail bad
// - Pull field: 01 up, 10 down, else none
// - Pins without pull-down ignore down selection
// - Level codes: 000 low, 001 high, 100 off
// - Edge codes: 101 rise, 110 fall, 111 both
// - Only enabled edge events wake oscillator
// - Detection configuration resets to low level
// - Any active pin event ungates module clock
// - Drive strength field picks 2 to 12mA
// - Slew bit: 0 slow, 1 fast, reset 0
// - Bank source drives written level on pin
// - Alternative source ignores bank bit writes
// - Alternative bit reads back written value
// - Unimplemented bank bits are reserved, read zero
// - Bit 10 selects bank or alternative data
// - Direction bit counts only for GPIO mux
// - Edge enable with code chooses event condition
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`include "gpc_consts.svh"
module gpc_top (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic main_rail_good,
  input wire logic secondary_rail_good,
  input wire logic [7:0] mux_is_gpio,
  input wire logic [7:0] func_out,
  input wire logic [7:0] func_oe,
  input wire logic [7:0] agg_int_en,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_od,
  output logic [7:0] pull_up_en,
  output logic [7:0] pull_down_en,
  output logic [15:0] drive_sel,
  output logic [7:0] slew_fast,
  output logic [7:0] pin_event,
  output logic ring_wake,
  output logic module_clk_req
);
  // Bank storage: the first eight pins live in the low byte of bank 0
  logic [31:0] bank0_r;
  logic [31:0] bank1_r;
  logic [31:0] bank2_r;
  logic [31:0] ctl_r [`GPC_NPINS];
  logic [31:0] ctl2_r [`GPC_NPINS];
  logic [31:0] rdata_nxt;
  logic [31:0] reg_rdata_r;
  logic [7:0] ev_lvl;
  logic [7:0] ev_edge;
  logic [7:0] out_nxt;
  logic [7:0] oe_nxt;
  logic [7:0] pu_nxt;
  logic [7:0] pd_nxt;
  logic [7:0] od_nxt;
  logic [7:0] slew_nxt;
  logic [15:0] drv_nxt;
  logic [7:0] wake_term;
  logic [7:0] clk_term;
  logic [7:0] pin_out_r;
  logic [7:0] pin_oe_r;
  logic [7:0] pin_od_r;
  logic [7:0] pu_r;
  logic [7:0] pd_r;
  logic [15:0] drv_r;
  logic [7:0] slew_r;
  logic [7:0] event_r;
  logic wake_r;
  logic clkreq_r;

  // Address decode
  wire hit_b0 = (reg_addr == `GPC_OFF_BANK0);
  wire hit_b1 = (reg_addr == `GPC_OFF_BANK1);
  wire hit_b2 = (reg_addr == `GPC_OFF_BANK2);
  wire hit_ctl = ({reg_addr[11:5], 5'h00} == `GPC_OFF_CTL_BASE) && (reg_addr[1:0] == 2'b00);
  wire hit_ctl2 = ({reg_addr[11:5], 5'h00} == `GPC_OFF_CTL2_BASE) && (reg_addr[1:0] == 2'b00);
  wire [`GPC_PIN_IDX_W-1:0] pidx = reg_addr[`GPC_PIN_IDX_LSB +: `GPC_PIN_IDX_W];

  // Write enables; a write to any other address is dropped
  wire wr_b0 = reg_wr & hit_b0;
  wire wr_b1 = reg_wr & hit_b1;
  wire wr_b2 = reg_wr & hit_b2;
  wire wr_ctl = reg_wr & hit_ctl;
  wire wr_ctl2 = reg_wr & hit_ctl2;

  // Read sources; bank reads are masked here and control registers on write, so reserved bits always read zero
  wire [31:0] rd_b0 = bank0_r & `GPC_BANK0_MASK;
  wire [31:0] rd_b1 = bank1_r & `GPC_BANK1_MASK;
  wire [31:0] rd_b2 = bank2_r & `GPC_BANK2_MASK;
  wire [31:0] rd_ctl = ctl_r[pidx];
  wire [31:0] rd_ctl2 = ctl2_r[pidx];

  // Pins without a pull-down, held as a vector so it can be indexed per pin
  wire [7:0] nopd_mask = `GPC_NOPD_MASK;

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (hit_b0)
      rdata_nxt = rd_b0;
    else if (hit_b1)
      rdata_nxt = rd_b1;
    else if (hit_b2)
      rdata_nxt = rd_b2;
    else if (hit_ctl)
      rdata_nxt = rd_ctl;
    else if (hit_ctl2)
      rdata_nxt = rd_ctl2;
  end

  // Bank 0; bits are stored even when the alternative source is chosen
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      bank0_r <= 32'h00000000;
    else if (wr_b0)
      bank0_r <= reg_wdata & `GPC_BANK0_MASK;
  end

  // Bank 1 has no pins in this group, kept for software read-back
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      bank1_r <= 32'h00000000;
    else if (wr_b1)
      bank1_r <= reg_wdata & `GPC_BANK1_MASK;
  end

  // Bank 2 has no pins in this group, kept for software read-back
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      bank2_r <= 32'h00000000;
    else if (wr_b2)
      bank2_r <= reg_wdata & `GPC_BANK2_MASK;
  end

  // Read data register, valid the cycle after the strobe only
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      reg_rdata_r <= 32'h00000000;
    else if (reg_rd)
      reg_rdata_r <= rdata_nxt;
    else
      reg_rdata_r <= 32'h00000000;
  end
  assign reg_rdata = reg_rdata_r;

  // Per-pin control registers, pad controls and event detectors
  genvar g;
  generate
    for (g = 0; g < `GPC_NPINS; g++)
    begin : g_pin
      wire [1:0] pull = ctl_r[g][`GPC_CTL_PULL_LSB +: 2];
      wire [1:0] pwr = ctl_r[g][`GPC_CTL_PWR_LSB +: 2];
      wire [3:0] det = {ctl_r[g][`GPC_CTL_EDGE_BIT], ctl_r[g][`GPC_CTL_DET_LSB +: 3]};
      wire src_bank = ctl_r[g][`GPC_CTL_SRC_BIT];
      wire gpio_dir = ctl_r[g][`GPC_CTL_DIR_BIT];
      wire alt_bit = ctl_r[g][`GPC_CTL_ALT_BIT];
      // Reserved rail codes keep the pad powered, treated as always good
      wire rail_ok = (pwr == gpc_pkg::GPC_PWR_MAIN) ? main_rail_good :
                     (pwr == gpc_pkg::GPC_PWR_SEC) ? secondary_rail_good : 1'b1;
      wire gpio_data = src_bank ? bank0_r[g] : alt_bit;
      wire dir_out = mux_is_gpio[g] ? gpio_dir : func_oe[g];
      // Reserved edge codes never pulse the detector, so this gate is safe for them
      wire is_edge = det[3] & (det != gpc_pkg::GPC_DET_OFF);

      always_ff @(posedge mclk)
      begin
        if (!rstn)
        begin
          ctl_r[g] <= `GPC_CTL_RST;
          ctl2_r[g] <= `GPC_CTL2_RST;
        end
        else if (wr_ctl && pidx == g)
          ctl_r[g] <= reg_wdata & `GPC_CTL_MASK;
        else if (wr_ctl2 && pidx == g)
          ctl2_r[g] <= reg_wdata & `GPC_CTL2_MASK;
      end

      // Pad data, enable and buffer type; open drain releases instead of driving high
      assign out_nxt[g] = mux_is_gpio[g] ? gpio_data : func_out[g];
      assign oe_nxt[g] = dir_out & rail_ok & ~(ctl_r[g][`GPC_CTL_OD_BIT] & out_nxt[g]);
      assign od_nxt[g] = ctl_r[g][`GPC_CTL_OD_BIT];

      // Pull, drive and slew
      assign pu_nxt[g] = (pull == gpc_pkg::GPC_PULL_UP);
      assign pd_nxt[g] = (pull == gpc_pkg::GPC_PULL_DOWN) & ~nopd_mask[g];
      assign drv_nxt[2*g +: 2] = ctl2_r[g][`GPC_CTL2_DRV_LSB +: 2];
      assign slew_nxt[g] = ctl2_r[g][`GPC_CTL2_SLEW_BIT];

      // Wake and clock request terms
      assign wake_term[g] = ev_edge[g] & is_edge & agg_int_en[g];
      assign clk_term[g] = ev_lvl[g];

      gpc_pin_event u_ev (
        .mclk(mclk),
        .rstn(rstn),
        .pin_in(pin_in[g]),
        .det_mode(det),
        .event_r(ev_lvl[g]),
        .edge_event_r(ev_edge[g])
      );
    end
  endgenerate

  // Pad data and enable, registered so the pads never see decode glitches
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pin_out_r <= 8'h00;
      pin_oe_r <= 8'h00;
    end
    else
    begin
      pin_out_r <= out_nxt;
      pin_oe_r <= oe_nxt;
    end
  end

  // Buffer type applies to every selected function, not only GPIO
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      pin_od_r <= 8'h00;
    else
      pin_od_r <= od_nxt;
  end

  // Pull enables
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      pu_r <= 8'h00;
      pd_r <= 8'h00;
    end
    else
    begin
      pu_r <= pu_nxt;
      pd_r <= pd_nxt;
    end
  end

  // Drive strength and slew rate
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      drv_r <= 16'h0000;
      slew_r <= 8'h00;
    end
    else
    begin
      drv_r <= drv_nxt;
      slew_r <= slew_nxt;
    end
  end

  // Event, wake and clock request share one stage so they line up in time
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      event_r <= 8'h00;
      wake_r <= 1'b0;
      clkreq_r <= 1'b0;
    end
    else
    begin
      event_r <= ev_lvl;
      wake_r <= |wake_term;
      clkreq_r <= |clk_term;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign pin_od = pin_od_r;
  assign pull_up_en = pu_r;
  assign pull_down_en = pd_r;
  assign drive_sel = drv_r;
  assign slew_fast = slew_r;
  assign pin_event = event_r;
  assign ring_wake = wake_r;
  assign module_clk_req = clkreq_r;
endmodule

// ===== verif/gpc_props.sv
// Port assertions for the pin control block
`timescale 1ns/100ps
module gpc_props (
  input logic mclk,
  input logic rstn,
  input logic [11:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  input logic main_rail_good,
  input logic secondary_rail_good,
  input logic [7:0] mux_is_gpio,
  input logic [7:0] agg_int_en,
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe,
  input logic [7:0] pull_up_en,
  input logic [7:0] pull_down_en,
  input logic [7:0] pin_event,
  input logic ring_wake,
  input logic module_clk_req
);
  logic [31:0] c0_r;
  logic b0_r;
  // Pin 0 control and bank bit as last written by software
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      c0_r <= 32'h0;
      b0_r <= 1'h0;
    end
    else if (reg_wr && reg_addr == 12'h000)
      c0_r <= reg_wdata;
    else if (reg_wr && reg_addr == 12'h280)
      b0_r <= reg_wdata[0];
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // Two samples of a dead rail leave time for the registered pad enable
  property p_rmain;
    (c0_r[3:2] == 2'h0 && !main_rail_good) [*2] |=> !pin_oe[0];
  endproperty
  a_rmain: assert property (p_rmain)
    else $error("pin 0 driven with main rail down");
  property p_rsec;
    (c0_r[3:2] == 2'h1 && !secondary_rail_good) [*2] |=> !pin_oe[0];
  endproperty
  a_rsec: assert property (p_rsec)
    else $error("pin 0 driven with secondary rail down");
  property p_pup;
    (c0_r[1:0] == 2'h1) [*3] |-> pull_up_en[0] && !pull_down_en[0];
  endproperty
  a_pup: assert property (p_pup)
    else $error("pull-up select not applied");
  property p_pdn;
    (c0_r[1:0] == 2'h2) [*3] |-> pull_down_en[0] && !pull_up_en[0];
  endproperty
  a_pdn: assert property (p_pdn)
    else $error("pull-down select not applied");
  property p_wake;
    ring_wake |-> (pin_event & agg_int_en) != 8'h0;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake without enabled pin event");
  property p_clk;
    $rose(pin_event != 8'h0) |-> ##[0:2] module_clk_req;
  endproperty
  a_clk: assert property (p_clk)
    else $error("pin event without clock request");
  property p_ctl;
    reg_rd && reg_addr == 12'h000 |=> reg_rdata == ($past(c0_r) & 32'h107ff);
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("pin 0 control read back wrong");
  property p_bank;
    (c0_r[10:8] == 3'h6 && mux_is_gpio[0] && $stable(b0_r)) [*3] |-> pin_out[0] == b0_r;
  endproperty
  a_bank: assert property (p_bank)
    else $error("pin 0 does not follow bank bit");
endmodule
bind gpc_top gpc_props u_props (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .main_rail_good, .secondary_rail_good, .mux_is_gpio, .agg_int_en, .pin_out,
  .pin_oe, .pull_up_en, .pull_down_en, .pin_event, .ring_wake, .module_clk_req);

// ===== verif/gpc_pad_model.sv
// Pad and board model: the board drives every pin the block releases
`timescale 1ns/100ps
module gpc_pad_model (
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe,
  input logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // A driven pad shows the block's level, a tristated one the board's
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// ===== verif/gpc_top_bench.sv
// Self-checking bench for the pin control block
`timescale 1ns/100ps
module gpc_top_bench;
  logic mclk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic main_rail_good = 1'h1, secondary_rail_good = 1'h1;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [7:0] mux_is_gpio = 8'hff, func_out = 8'h0, func_oe = 8'h0;
  logic [7:0] agg_int_en = 8'hff, ext_val = 8'hff;
  logic [31:0] reg_rdata;
  logic [15:0] drive_sel;
  logic [7:0] pin_in, pin_out, pin_oe, pin_od, pull_up_en, pull_down_en, slew_fast, pin_event;
  logic ring_wake, module_clk_req;
  int bad_count = 0;
  int n_compared = 0;
  // Event cases: code, level before, level after, event seen, wake seen
  logic [7:0] tbl [9] = '{8'h0a, 8'h16, 8'h48, 8'h28, 8'h78, 8'hd7, 8'he4, 8'heb, 8'hfb};
  always #4 mclk = ~mclk;
  gpc_top u_dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .main_rail_good, .secondary_rail_good, .mux_is_gpio, .func_out, .func_oe, .agg_int_en,
    .pin_in, .pin_out, .pin_oe, .pin_od, .pull_up_en, .pull_down_en, .drive_sel,
    .slew_fast, .pin_event, .ring_wake, .module_clk_req);
  gpc_pad_model u_pads (.pin_out, .pin_oe, .ext_val, .pin_in);
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Writes leave a free cycle so a strobe is never set twice in one step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  // Read data stand for one cycle only, so look mid-cycle
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(negedge mclk);
    chk(n, e, reg_rdata);
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Pin 3 event case; counts start once the old level has settled
  task automatic ev(input logic [7:0] t);
    int ne, nw, nc;
    wr(12'h00c, {24'h0, t[7:4], 4'h0});
    @(posedge mclk);
    ext_val[3] <= t[3];
    w(8);
    ne = 0;
    nw = 0;
    nc = 0;
    @(posedge mclk);
    ext_val[3] <= t[2];
    repeat (10)
    begin
      @(negedge mclk);
      ne += (pin_event[3] !== 1'h0);
      nw += (ring_wake !== 1'h0);
      nc += (module_clk_req !== 1'h0);
    end
    chk("event", t[1], ne > 0);
    chk("wake", t[0], nw > 0);
    chk("clk req", t[1], nc > 0);
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'h1;
    rd(12'h000, 32'h0, "ctl0 reset");
    rd(12'h100, 32'h0, "ctl2 reset");
    wr(12'h004, 32'hffffffff);
    rd(12'h004, 32'h107ff, "ctl1 mask");
    wr(12'h004, 32'h40);
    wr(12'h104, 32'hffffffff);
    rd(12'h104, 32'h31, "ctl2 mask");
    wr(12'h280, 32'hffffffff);
    rd(12'h280, 32'h7fffffff, "bank0");
    rd(12'h28c, 32'h0, "unmapped");
    wr(12'h000, 32'h640);
    wr(12'h280, 32'h0);
    w(3);
    chk("out0 low", 0, pin_out[0]);
    wr(12'h280, 32'h1);
    w(3);
    chk("out0 high", 1, pin_out[0]);
    wr(12'h000, 32'h240);
    w(3);
    chk("out0 alt0", 0, pin_out[0]);
    wr(12'h000, 32'h10240);
    wr(12'h280, 32'h0);
    w(3);
    chk("out0 alt1", 1, pin_out[0]);
    rd(12'h000, 32'h10240, "alt bit");
    wr(12'h000, 32'h640);
    @(posedge mclk);
    main_rail_good <= 1'h0;
    w(3);
    chk("oe0 main", 0, pin_oe[0]);
    wr(12'h000, 32'h644);
    w(3);
    chk("oe0 sec on", 1, pin_oe[0]);
    @(posedge mclk);
    secondary_rail_good <= 1'h0;
    w(3);
    chk("oe0 sec off", 0, pin_oe[0]);
    @(posedge mclk);
    main_rail_good <= 1'h1;
    secondary_rail_good <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h000, 32'h40 | i);
      wr(12'h108, {26'h0, i[1:0], 3'h0, i[0]});
      w(3);
      chk("pull up", i == 1, pull_up_en[0]);
      chk("pull down", i == 2, pull_down_en[0]);
      chk("drive", i, drive_sel[5:4]);
      chk("slew", i[0], slew_fast[2]);
    end
    // Function path owns the pad once the mux leaves GPIO; direction bit is clear
    wr(12'h000, 32'h140);
    mux_is_gpio <= 8'hfe;
    func_oe <= 8'h01;
    w(3);
    chk("func out low", 0, pin_out[0]);
    chk("func oe", 1, pin_oe[0]);
    chk("func od", 1, pin_od[0]);
    @(posedge mclk);
    func_out <= 8'h01;
    w(3);
    chk("func out high", 1, pin_out[0]);
    chk("func od release", 0, pin_oe[0]);
    @(posedge mclk);
    mux_is_gpio <= 8'hff;
    func_out <= 8'h00;
    func_oe <= 8'h00;
    foreach (tbl[k])
      ev(tbl[k]);
    @(posedge mclk);
    agg_int_en <= 8'h0;
    ev(8'hd6);
    print_verdict();
  end
  // The tests take a few hundred cycles; this bound is far beyond that
  initial
  begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
